/* File: dmtr_consts.svh */
`ifndef DMTR_CONSTS_SVH
`define DMTR_CONSTS_SVH

// ****************************************************************
// mode register addresses
// ****************************************************************
`define DMTR_MA_TRAIN 6'h0D
`define DMTR_MA_DQREF 6'h0E
`define DMTR_MA_INV 6'h0F

// ****************************************************************
// training control bit positions
// ****************************************************************
`define DMTR_TC_BUS_TRAIN 0
`define DMTR_TC_PREAMBLE 1
`define DMTR_TC_REF_OUT 2
`define DMTR_TC_FAST_SETTLE 3
`define DMTR_TC_RATE_OPT 4
`define DMTR_TC_MASK_DIS 5
`define DMTR_TC_SP_WRITE 6
`define DMTR_TC_SP_OPER 7

// ****************************************************************
// dq reference field layout
// ****************************************************************
`define DMTR_REF_RANGE 6
`define DMTR_REF_LVL_MSB 5
`define DMTR_REF_LVL_MAX 6'h32
`define DMTR_REF_USED_MASK 8'h7F

// ****************************************************************
// reset values
// ****************************************************************
`define DMTR_RST_TRAIN 8'h00
`define DMTR_RST_DQREF 8'h4D
`define DMTR_RST_INV 8'h55

// ****************************************************************
// refresh-rate codes
// ****************************************************************
`define DMTR_RR_FAST1 3'h1
`define DMTR_RR_FAST2 3'h2
`define DMTR_RR_SUBST 3'h3

// ****************************************************************
// calibration burst
// ****************************************************************
`define DMTR_CAL_LAST 4'hF
`define DMTR_CAL_HALF 3
`define DMTR_CAL_IDX_MSB 2
`define DMTR_CAL_ST_BURST 1
`define DMTR_CA_PAD 2'h0
`define DMTR_OE_ALL 8'hFF
`define DMTR_OE_NONE 8'h00
`define DMTR_BYTE_ZERO 8'h00

`endif

/* File: dmtr_pkg.sv */
package dmtr_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    DMTR_CAL_IDLE  = 2'b01,
    DMTR_CAL_BURST = 2'b10
  } dmtr_cal_t;

  typedef struct packed {
    logic cke_s1;
    logic cke_s2;
    logic cke_s3;
    logic cke_val;
    logic [5:0] ca_s1;
    logic [5:0] ca_s2;
    logic [5:0] ca_s3;
    logic [5:0] ca_val;
    logic [7:0] train;
    logic [7:0] dqref0;
    logic [7:0] dqref1;
    logic [7:0] op_ref;
    logic [7:0] inv;
    dmtr_cal_t cal;
    logic [3:0] beat;
    logic [7:0] dq;
    logic [7:0] dq_oe;
    logic mask_inversion_pin;
    logic dmi_oe;
    logic mrr_vld;
    logic [7:0] mrr_data;
    logic [2:0] rr_report;
    logic dbi_act;
    logic bus_map;
  } dmtr_state_t;

endpackage : dmtr_pkg

/* File: dmtr_mode_regs.sv */
// Overview of operation
// - write-only training control holds eight mode bits from bit 0, all reset 0
// - writing bus training enable one enters command-bus training
// - training with cke low ignores commands and maps ca onto dq
// - reference output shows operating set-point reference levels on dq pins
// - fast-settle bit selects high-current reference generator mode
// - refresh-rate option acts only when basic info bit zero is one
// - option zero reports 011b in place of 001b or 010b
// - two set-point copies, writes and reads reach the write-selected one
// - device operates from the operate-selected copy only
// - reference holds level code 5:0 and range 6, codes above 110010 reserved
// - range 0 starts at 10.0 percent, range 1 at 22.0, 0.4 per step
// - reset gives range 1 level 001101, writes kept until reset
// - reference read drives bits 7:0 on dq, reserved bits zero
// - write-only lower invert register, one inverts pattern per dq, reset 55h
// - mask/inversion pin carries true calibration data, never inverted
// - no data bus inversion during read calibration
`include "dmtr_consts.svh"

module dmtr_mode_regs
  import dmtr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cke,
  input wire logic [5:0] ca,
  input wire logic cmd_mrw,
  input wire logic cmd_mrr,
  input wire logic [5:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic basic_info_rate_cap,
  input wire logic [2:0] temp_rate_code,
  input wire logic dbi_enable,
  input wire logic cal_start,
  input wire logic [7:0] cal_pattern_a,
  input wire logic [7:0] cal_pattern_b,
  output logic mrr_valid,
  output logic [7:0] mrr_data,
  output logic [7:0] dq_out,
  output logic [7:0] dq_oe,
  output logic mask_inversion_pin_out,
  output logic mask_inversion_pin_oe,
  output logic bus_training_active,
  output logic preamble_training_enable,
  output logic reference_fast_settle,
  output logic data_mask_disable,
  output logic [5:0] dq_reference_level,
  output logic dq_reference_range,
  output logic [2:0] refresh_rate_report,
  output logic dbi_active,
  output logic cal_active
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_s1_ff;
  logic rst_n_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  dmtr_state_t st_ff;
  dmtr_state_t nxt_st;
  logic cmd_block;
  logic wr_ok;
  logic rd_ok;
  logic pat_bit;
  logic [7:0] rd_copy;

  always_comb
  begin
    nxt_st = st_ff;
    pat_bit = 1'b0;
    rd_copy = `DMTR_BYTE_ZERO;

    // pin synchronisers, a change counts once stages two and three agree
    nxt_st.cke_s1 = cke;
    nxt_st.cke_s2 = st_ff.cke_s1;
    nxt_st.cke_s3 = st_ff.cke_s2;
    if (st_ff.cke_s2 == st_ff.cke_s3)
    begin
      nxt_st.cke_val = st_ff.cke_s3;
    end
    nxt_st.ca_s1 = ca;
    nxt_st.ca_s2 = st_ff.ca_s1;
    nxt_st.ca_s3 = st_ff.ca_s2;
    if (st_ff.ca_s2 == st_ff.ca_s3)
    begin
      nxt_st.ca_val = st_ff.ca_s3;
    end

    // commands are dropped while training with cke low
    cmd_block = st_ff.train[`DMTR_TC_BUS_TRAIN] & ~st_ff.cke_val;
    wr_ok = cmd_mrw & ~cmd_block;
    rd_ok = cmd_mrr & ~cmd_block;

    // ****************************************************************
    // mode register write
    // ****************************************************************
    if (wr_ok)
    begin
      unique case (cmd_addr)
        `DMTR_MA_TRAIN:
        begin
          nxt_st.train = cmd_wdata;
        end
        `DMTR_MA_DQREF:
        begin
          // reserved level codes leave the copy untouched
          if (cmd_wdata[`DMTR_REF_LVL_MSB:0] <= `DMTR_REF_LVL_MAX)
          begin
            if (st_ff.train[`DMTR_TC_SP_WRITE])
            begin
              nxt_st.dqref1 = cmd_wdata & `DMTR_REF_USED_MASK;
            end
            else
            begin
              nxt_st.dqref0 = cmd_wdata & `DMTR_REF_USED_MASK;
            end
          end
        end
        `DMTR_MA_INV:
        begin
          nxt_st.inv = cmd_wdata;
        end
        default:
        begin
          nxt_st.inv = st_ff.inv;
        end
      endcase
    end

    // ****************************************************************
    // mode register read
    // ****************************************************************
    if (st_ff.train[`DMTR_TC_SP_WRITE])
    begin
      rd_copy = st_ff.dqref1;
    end
    else
    begin
      rd_copy = st_ff.dqref0;
    end
    nxt_st.mrr_vld = rd_ok;
    nxt_st.mrr_data = `DMTR_BYTE_ZERO;
    if (rd_ok)
    begin
      // write-only registers and unknown addresses read back as zero
      unique case (cmd_addr)
        `DMTR_MA_DQREF:
        begin
          nxt_st.mrr_data = rd_copy & `DMTR_REF_USED_MASK;
        end
        `DMTR_MA_TRAIN, `DMTR_MA_INV:
        begin
          nxt_st.mrr_data = `DMTR_BYTE_ZERO;
        end
        default:
        begin
          nxt_st.mrr_data = `DMTR_BYTE_ZERO;
        end
      endcase
    end

    // operating copy follows the operate select
    if (nxt_st.train[`DMTR_TC_SP_OPER])
    begin
      nxt_st.op_ref = nxt_st.dqref1;
    end
    else
    begin
      nxt_st.op_ref = nxt_st.dqref0;
    end

    // ****************************************************************
    // calibration burst
    // ****************************************************************
    unique case (st_ff.cal)
      DMTR_CAL_IDLE:
      begin
        nxt_st.beat = 4'h0;
        if (cal_start && !cmd_block)
        begin
          nxt_st.cal = DMTR_CAL_BURST;
        end
      end
      DMTR_CAL_BURST:
      begin
        if (st_ff.beat == `DMTR_CAL_LAST)
        begin
          nxt_st.cal = DMTR_CAL_IDLE;
          nxt_st.beat = 4'h0;
        end
        else
        begin
          nxt_st.beat = st_ff.beat + 4'h1;
        end
      end
    endcase

    // first eight beats from pattern a, last eight from pattern b
    if (nxt_st.beat[`DMTR_CAL_HALF])
    begin
      pat_bit = cal_pattern_b[nxt_st.beat[`DMTR_CAL_IDX_MSB:0]];
    end
    else
    begin
      pat_bit = cal_pattern_a[nxt_st.beat[`DMTR_CAL_IDX_MSB:0]];
    end

    // ****************************************************************
    // dq drive
    // ****************************************************************
    // read answer beats calibration, which beats training map and reference
    nxt_st.bus_map = nxt_st.train[`DMTR_TC_BUS_TRAIN] & ~nxt_st.cke_val;
    nxt_st.mask_inversion_pin = 1'b0;
    nxt_st.dmi_oe = 1'b0;
    if (nxt_st.mrr_vld)
    begin
      nxt_st.dq = nxt_st.mrr_data;
      nxt_st.dq_oe = `DMTR_OE_ALL;
    end
    else if (nxt_st.cal == DMTR_CAL_BURST)
    begin
      nxt_st.dq = {8{pat_bit}} ^ nxt_st.inv;
      nxt_st.dq_oe = `DMTR_OE_ALL;
      nxt_st.mask_inversion_pin = pat_bit;
      nxt_st.dmi_oe = 1'b1;
    end
    else if (nxt_st.bus_map)
    begin
      nxt_st.dq = {`DMTR_CA_PAD, nxt_st.ca_val};
      nxt_st.dq_oe = `DMTR_OE_ALL;
    end
    else if (nxt_st.train[`DMTR_TC_REF_OUT])
    begin
      nxt_st.dq = nxt_st.op_ref;
      nxt_st.dq_oe = `DMTR_OE_ALL;
    end
    else
    begin
      nxt_st.dq = `DMTR_BYTE_ZERO;
      nxt_st.dq_oe = `DMTR_OE_NONE;
    end

    // ****************************************************************
    // refresh-rate report and inversion
    // ****************************************************************
    nxt_st.rr_report = temp_rate_code;
    if (basic_info_rate_cap && !nxt_st.train[`DMTR_TC_RATE_OPT])
    begin
      unique case (temp_rate_code)
        `DMTR_RR_FAST1, `DMTR_RR_FAST2:
        begin
          nxt_st.rr_report = `DMTR_RR_SUBST;
        end
        default:
        begin
          nxt_st.rr_report = temp_rate_code;
        end
      endcase
    end
    nxt_st.dbi_act = dbi_enable & (nxt_st.cal == DMTR_CAL_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      st_ff.cke_s1 <= 1'b0;
      st_ff.cke_s2 <= 1'b0;
      st_ff.cke_s3 <= 1'b0;
      st_ff.cke_val <= 1'b0;
      st_ff.ca_s1 <= '0;
      st_ff.ca_s2 <= '0;
      st_ff.ca_s3 <= '0;
      st_ff.ca_val <= '0;
      st_ff.train <= `DMTR_RST_TRAIN;
      // both set-point copies start at the default reference
      st_ff.dqref0 <= `DMTR_RST_DQREF;
      st_ff.dqref1 <= `DMTR_RST_DQREF;
      st_ff.op_ref <= `DMTR_RST_DQREF;
      st_ff.inv <= `DMTR_RST_INV;
      st_ff.cal <= DMTR_CAL_IDLE;
      st_ff.beat <= '0;
      st_ff.dq <= `DMTR_BYTE_ZERO;
      st_ff.dq_oe <= `DMTR_OE_NONE;
      st_ff.mask_inversion_pin <= 1'b0;
      st_ff.dmi_oe <= 1'b0;
      st_ff.mrr_vld <= 1'b0;
      st_ff.mrr_data <= `DMTR_BYTE_ZERO;
      st_ff.rr_report <= '0;
      st_ff.dbi_act <= 1'b0;
      st_ff.bus_map <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mrr_valid = st_ff.mrr_vld;
  assign mrr_data = st_ff.mrr_data;
  assign dq_out = st_ff.dq;
  assign dq_oe = st_ff.dq_oe;
  assign mask_inversion_pin_out = st_ff.mask_inversion_pin;
  assign mask_inversion_pin_oe = st_ff.dmi_oe;
  assign bus_training_active = st_ff.bus_map;
  assign preamble_training_enable = st_ff.train[`DMTR_TC_PREAMBLE];
  assign reference_fast_settle = st_ff.train[`DMTR_TC_FAST_SETTLE];
  assign data_mask_disable = st_ff.train[`DMTR_TC_MASK_DIS];
  assign dq_reference_level = st_ff.op_ref[`DMTR_REF_LVL_MSB:0];
  assign dq_reference_range = st_ff.op_ref[`DMTR_REF_RANGE];
  assign refresh_rate_report = st_ff.rr_report;
  assign dbi_active = st_ff.dbi_act;
  // one-hot burst bit drives the flag straight from its flop
  assign cal_active = st_ff.cal[`DMTR_CAL_ST_BURST];

endmodule : dmtr_mode_regs

/* File: dmtr_mode_regs_monitor.sv */
module dmtr_mode_regs_mon (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_mrw,
  input wire logic cmd_mrr,
  input wire logic [7:0] cal_pattern_a,
  input wire logic mrr_valid,
  input wire logic [7:0] mrr_data,
  input wire logic [7:0] dq_out,
  input wire logic [7:0] dq_oe,
  input wire logic mask_inversion_pin_out,
  input wire logic bus_training_active,
  input wire logic [5:0] dq_reference_level,
  input wire logic dq_reference_range,
  input wire logic dbi_active,
  input wire logic cal_active
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_read_answer: assert property (cmd_mrr && !bus_training_active |=> mrr_valid)
    else $error("read not answered");
  a_read_drive: assert property (mrr_valid |-> dq_out == mrr_data && !mrr_data[7])
    else $error("bad read drive");
  a_train_drop: assert property (bus_training_active && cmd_mrr |=> !mrr_valid)
    else $error("read taken in training");
  a_map_zero: assert property (bus_training_active && !mrr_valid && !cal_active
    |-> dq_oe == 8'hFF && dq_out[7:6] == 2'h0) else $error("bad training map");
  a_ref_hold: assert property (!$past(cmd_mrw) |-> $stable(dq_reference_level)
    && $stable(dq_reference_range)) else $error("reference moved");
  a_cal_len: assert property ($rose(cal_active) |-> cal_active[*8] ##1 cal_active[*8]
    ##1 !cal_active) else $error("bad burst length");
  a_dmi_true: assert property ($rose(cal_active) |->
    mask_inversion_pin_out == cal_pattern_a[0]) else $error("mask pin inverted");
  a_dbi_off: assert property (cal_active |-> !dbi_active) else $error("inversion on");
  c_burst: cover property ($rose(cal_active));
  c_train: cover property ($rose(bus_training_active));
  c_read: cover property (mrr_valid && mrr_data[6]);
endmodule : dmtr_mode_regs_mon
bind dmtr_mode_regs dmtr_mode_regs_mon u_mon (.*);

/* File: dmtr_ctl_model.sv */
module dmtr_ctl_model (
  input wire logic clk,
  input wire logic mrr_valid,
  input wire logic [7:0] mrr_data,
  output logic cmd_mrw,
  output logic cmd_mrr,
  output logic [5:0] cmd_addr,
  output logic [7:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_mrw = 1'b0;
    cmd_mrr = 1'b0;
    cmd_addr = 6'h00;
    cmd_wdata = 8'h00;
  end
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    cmd_mrw <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_mrw <= 1'b0;
    cmd_wdata <= ~d;
  endtask : mrw
  task automatic mrr(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    cmd_mrr <= 1'b1;
    cmd_addr <= a;
    @(posedge clk);
    cmd_mrr <= 1'b0;
    #1;
    d = mrr_valid === 1'b1 ? mrr_data : 8'hEE;
  endtask : mrr
endmodule : dmtr_ctl_model

/* File: dmtr_mode_regs_tb_top.sv */
module dmtr_mode_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, cke = 1'b1, cal_start = 1'b0;
  logic dbi_enable = 1'b1, basic_info_rate_cap = 1'b0;
  logic [2:0] temp_rate_code = 3'h0;
  logic [5:0] ca = 6'h00;
  logic [7:0] cal_pattern_a = 8'h96, cal_pattern_b = 8'h3A;
  logic cmd_mrw, cmd_mrr, mrr_valid, mask_inversion_pin_out, mask_inversion_pin_oe;
  logic bus_training_active, preamble_training_enable, reference_fast_settle;
  logic data_mask_disable, dq_reference_range, dbi_active, cal_active;
  logic [2:0] refresh_rate_report;
  logic [5:0] cmd_addr, dq_reference_level;
  logic [7:0] cmd_wdata, mrr_data, dq_out, dq_oe, d, e;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] rows [7] = '{32'h0E323232, 32'h0E727272, 32'h0E337272, 32'h0EC04040,
    32'h0E000000, 32'h0F3C0000, 32'h0D000000};
  wire logic [7:0] ref_out = {1'b0, dq_reference_range, dq_reference_level};
  wire logic [7:0] ctl_bits = {5'h0, preamble_training_enable, reference_fast_settle,
    data_mask_disable};
  dmtr_mode_regs dut (.*);
  dmtr_ctl_model u_ctl (.*);
  always #10 clk = ~clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    miscompares += int'(got !== exp);
  endtask : check
  task automatic complete_run();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cal_burst(input logic [7:0] inv);
    logic b;
    @(posedge clk);
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      #1;
      b = k < 8 ? cal_pattern_a[k] : cal_pattern_b[k - 8];
      check(dq_out, {8{b}} ^ inv);
      check({6'h0, mask_inversion_pin_out, dbi_active}, {6'h0, b, 1'b0});
      check({6'h0, cal_active, mask_inversion_pin_oe}, 8'h03);
      check(dq_oe, 8'hFF);
      @(posedge clk);
    end
  endtask : cal_burst
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(ref_out, 8'h4D);
    check(ctl_bits, 8'h00);
    u_ctl.mrr(6'h0E, d);
    check(d, 8'h4D);
    cal_burst(8'h55);
    foreach (rows[i])
    begin
      u_ctl.mrw(rows[i][29:24], rows[i][23:16]);
      #1;
      check(ref_out, rows[i][7:0]);
      u_ctl.mrr(rows[i][29:24], d);
      check(d, rows[i][15:8]);
    end
    cal_burst(8'h3C);
    u_ctl.mrw(6'h0D, 8'h40);
    u_ctl.mrw(6'h0E, 8'h45);
    #1;
    check(ref_out, 8'h00);
    u_ctl.mrr(6'h0E, d);
    check(d, 8'h45);
    u_ctl.mrw(6'h0D, 8'hAE);
    #1;
    check(ref_out, 8'h45);
    check(ctl_bits, 8'h07);
    u_ctl.mrr(6'h0E, d);
    check(d, 8'h00);
    @(posedge clk);
    #1;
    check(dq_out & dq_oe, 8'h45);
    for (int i = 0; i < 32; i++)
    begin
      if (i == 16)
        u_ctl.mrw(6'h0D, 8'hBE);
      @(posedge clk);
      temp_rate_code <= i[2:0];
      basic_info_rate_cap <= i[3];
      e = {5'h0, i[2:0]};
      if (i[3] && !i[4] && (e == 8'h01 || e == 8'h02))
        e = 8'h03;
      repeat (3) @(posedge clk);
      #1;
      check({5'h0, refresh_rate_report}, e);
    end
    u_ctl.mrw(6'h0D, 8'h01);
    @(posedge clk);
    cke <= 1'b0;
    ca <= 6'h2B;
    repeat (8) @(posedge clk);
    #1;
    check(dq_out, 8'h2B);
    check({7'h0, bus_training_active}, 8'h01);
    u_ctl.mrr(6'h0E, d);
    check(d, 8'hEE);
    @(posedge clk);
    cke <= 1'b1;
    repeat (8) @(posedge clk);
    u_ctl.mrw(6'h0D, 8'h00);
    #1;
    check({7'h0, bus_training_active}, 8'h00);
    check({7'h0, dbi_active}, 8'h01);
    @(posedge clk);
    cke <= 1'b0;
    dbi_enable <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check({7'h0, bus_training_active}, 8'h00);
    check({dq_oe[7:1], dbi_active}, 8'h00);
    u_ctl.mrr(6'h0E, d);
    check(d, 8'h00);
    @(posedge clk);
    cke <= 1'b1;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(ref_out, 8'h4D);
    check(ctl_bits, 8'h00);
    complete_run();
  end
endmodule : dmtr_mode_regs_tb_top
